// ### rtl/reg_pulse_pkg.sv
// Shared constants for the program register transfer control block
package reg_pulse_pkg;
  // ==========================================================
  // Counter time levels (octal level numbers held as values)
  localparam logic [4:0] PK_L00 = 5'h00;
  localparam logic [4:0] PK_L10 = 5'h08;
  localparam logic [4:0] PK_L11 = 5'h09;
  localparam logic [4:0] PK_L13 = 5'h0b;
  localparam logic [4:0] PK_L15 = 5'h0d;
  localparam logic [4:0] PK_L24 = 5'h14;
  localparam logic [4:0] PK_L25 = 5'h15;
  localparam logic [4:0] PK_L27 = 5'h17;
  localparam logic [4:0] PK_L31 = 5'h19;
  localparam logic [4:0] QK_L00 = 5'h00;
  localparam logic [4:0] QK_L01 = 5'h01;
  localparam logic [4:0] QK_L15 = 5'h0d;
  localparam logic [4:0] QK_L21 = 5'h11;
  localparam logic [2:0] CS_L01 = 3'h1;
  localparam logic [2:0] CS_L02 = 3'h2;
  localparam logic [2:0] CS_L03 = 3'h3;
  localparam logic [2:0] CS_L04 = 3'h4;
  // ==========================================================
  // Pulse vector bit positions
  localparam int NPULSE        = 16;
  localparam int P_N_CLR       = 0;
  localparam int P_N_CLR_LOW   = 1;
  localparam int P_E_TO_N      = 2;
  localparam int P_E_LO_TO_N   = 3;
  localparam int P_XA_TO_P     = 4;
  localparam int P_XA29_TO_P29 = 5;
  localparam int P_P_INC       = 6;
  localparam int P_XA_TO_Q     = 7;
  localparam int P_N_TO_K      = 8;
  localparam int P_XM_TO_X     = 9;
  localparam int P_X_CLR       = 10;
  localparam int P_P_TO_X      = 11;
  localparam int P_XA_TO_X     = 12;
  localparam int P_X_COMP      = 13;
  localparam int P_X_PAR_SET   = 14;
  // ==========================================================
  // AXI4-Lite register map
  localparam logic [3:0] ADDR_CTRL   = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam logic [3:0] ADDR_LAST   = 4'h8;
  localparam logic [3:0] ADDR_COUNT  = 4'hc;
  localparam int CTRL_AUTO_START = 0;
  localparam int CTRL_ALARM_SUP  = 1;
  localparam int CTRL_ENABLE     = 2;
  localparam logic [2:0] CTRL_RESET = 3'h4;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : reg_pulse_pkg

// ### rtl/reg_pulse_ctrl.sv
// Register-driver pulse generator for the program element registers
// How it works
// R1: Level 10 clears word; legal else low quarters
// R2: Index-jump class clears word at 25 release
// R3: Clear word at operand 01, sequence step 01
// R4: Third quarter never cleared, only jammed
// R5: Level 11 copies E into word register
// R6: Operand 15/21 copies E low half
// R7: Program counter loads only adder; increment spares 2.9
// R8: Adder jam needs auto start or no alarm
// R9: Adder-to-PC at release, 31 jumps, step 04
// R10: Metabit copied only during sequence change
// R11: Increment at 24; again for held skip
// R12: Adder to operand address at 00 interlocks
// R13: Step 03 jams word bits to sequence number
// R14: Index strobe at 13 or new-PC read
// R15: Unread own-PC register gets clear instead
// R16: First-reference set on change, cleared on use
// R17: PC to index buffer at 31/04 if parity ok
// R18: Adder to buffer only six index instructions
// R19: Buffer clear also sets parity flip-flop
// R20: Positive index jump complements at 15, 25
// R21: Index skip complements 15, recomplements 27/31
// R22: One pulse per qualifying counter time level; P_XA_TO_X is held for as long as its conditions hold
`timescale 1ns/1ps
`default_nettype none
module reg_pulse_ctrl
  import reg_pulse_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Counter time levels, step strobes are one cycle per level entry
  input  wire logic        pk_step_i,
  input  wire logic [4:0]  pk_level_i,
  input  wire logic        pk_release_i,
  input  wire logic        qk_step_i,
  input  wire logic [4:0]  qk_level_i,
  input  wire logic        cs_step_i,
  input  wire logic [2:0]  cs_level_i,
  // Instruction class and condition levels
  input  wire logic        sel_legal_i,
  input  wire logic        final_deferred_i,
  input  wire logic        jx_class_i,
  input  wire logic        operand_index_i,
  input  wire logic        ff_memory_cycle_i,
  input  wire logic        index_operand_i,
  input  wire logic        plain_jump_i,
  input  wire logic        arithmetic_jump_condition_i,
  input  wire logic        index_jump_condition_i,
  input  wire logic        alarm_i,
  input  wire logic        skip_instr_i,
  input  wire logic        skip_cond_i,
  input  wire logic        operand_start_interlock_i,
  input  wire logic        deferred_start_i,
  input  wire logic        deferred_interlock_i,
  input  wire logic        index_sel_zero_i,
  input  wire logic        pc_reg_match_i,
  input  wire logic        jump_save_i,
  input  wire logic        index_parity_alarm_i,
  input  wire logic        index_modify_i,
  input  wire logic        index_write_i,
  input  wire logic        positive_index_jump_i,
  input  wire logic        index_skip_i,
  input  wire logic        e_busy_flag_i,
  input  wire logic        cf3_differs_i,
  input  wire logic        cf3_i,
  input  wire logic        cf1_i,
  // Register-driver pulses
  output logic             n_clear_o,
  output logic             n_clear_low_o,
  output logic             e_to_n_o,
  output logic             e_low_to_n_low_o,
  output logic             xa_to_p_o,
  output logic             xa29_to_p29_o,
  output logic             p_inc_o,
  output logic             xa_to_q_o,
  output logic             n_to_k_o,
  output logic             xmem_to_x_o,
  output logic             x_clear_o,
  output logic             x_parity_set_o,
  output logic             p_to_x_o,
  output logic             xa_to_x_o,
  output logic             x_complement_o,
  output logic             first_reference_flag_o,
  // AXI4-Lite slave
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);

  // ==========================================================
  // State
  typedef struct packed {
    logic [2:0]        ctrl;
    logic              first_ref;
    logic [NPULSE-1:0] pulse;
    logic [NPULSE-1:0] last;
    logic [15:0]       count;
    logic              aw_have;
    logic [3:0]        aw_addr;
    logic              w_have;
    logic [31:0]       w_data;
    logic [3:0]        w_strb;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              rvalid;
    logic [31:0]       rdata;
    logic [1:0]        rresp;
  } state_t;

  state_t s_q;
  state_t s_d;

  // Byte-lane merge, used for every writable word
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] data,
                                        input logic [3:0]  strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = data[8*i +: 8];
      end
    end
    return r;
  endfunction : merge

  // ==========================================================
  // Time level decode, each step strobe lasts one cycle
  logic pk10, pk11, pk13, pk15, pk24, pk25, pk27, pk31, pk00;
  logic qk00, qk01, qk15, qk21;
  logic cs01, cs02, cs03, cs04;
  logic jam_ok, index_parity_alarm_ok, index_read, p;
  logic [NPULSE-1:0] pv;

  always_comb begin
    pk00 = pk_step_i && (pk_level_i == PK_L00);
    pk10 = pk_step_i && (pk_level_i == PK_L10);
    pk11 = pk_step_i && (pk_level_i == PK_L11);
    pk13 = pk_step_i && (pk_level_i == PK_L13);
    pk15 = pk_step_i && (pk_level_i == PK_L15);
    pk24 = pk_step_i && (pk_level_i == PK_L24);
    pk25 = pk_step_i && (pk_level_i == PK_L25);
    pk27 = pk_step_i && (pk_level_i == PK_L27);
    pk31 = pk_step_i && (pk_level_i == PK_L31);
    qk00 = qk_step_i && (qk_level_i == QK_L00);
    qk01 = qk_step_i && (qk_level_i == QK_L01);
    qk15 = qk_step_i && (qk_level_i == QK_L15);
    qk21 = qk_step_i && (qk_level_i == QK_L21);
    cs01 = cs_step_i && (cs_level_i == CS_L01);
    cs02 = cs_step_i && (cs_level_i == CS_L02);
    cs03 = cs_step_i && (cs_level_i == CS_L03);
    cs04 = cs_step_i && (cs_level_i == CS_L04);
  end

  // ==========================================================
  // Pulse decode; every pulse but P_XA_TO_X is a single-cycle OR of terms each gated by a level or release strobe
  always_comb begin
    pv      = '0;
    jam_ok  = s_q.ctrl[CTRL_AUTO_START] || !alarm_i;                  // [R8]
    index_parity_alarm_ok = !index_parity_alarm_i || s_q.ctrl[CTRL_ALARM_SUP];      // [R17]
    // Word register clears; third quarter has no clear line at all     [R4]
    pv[P_N_CLR]     = (pk10 && (sel_legal_i || final_deferred_i))     // [R1]
                   || (pk_release_i && jx_class_i)                     // [R2]
                   || (qk01 && operand_index_i) || cs01;               // [R3]
    pv[P_N_CLR_LOW] = pk10 && !(sel_legal_i || final_deferred_i);     // [R1]
    pv[P_E_TO_N]    = pk11 && ff_memory_cycle_i;                      // [R5]
    pv[P_E_LO_TO_N] = (qk15 || qk21) && index_operand_i;              // [R6]
    // Adder is the only load path into the program counter            [R7]
    p = (pk_release_i && index_jump_condition_i)
     || (pk31 && (plain_jump_i || arithmetic_jump_condition_i))
     || cs04;                                                          // [R9]
    pv[P_XA_TO_P]     = p && jam_ok;                                  // [R8]
    pv[P_XA29_TO_P29] = cs04 && jam_ok;                               // [R10]
    pv[P_P_INC]       = pk24 || (pk31 && skip_instr_i && skip_cond_i); // [R11]
    pv[P_XA_TO_Q]     = (qk00 && operand_start_interlock_i)
                     || (pk00 && deferred_start_i && deferred_interlock_i); // [R12]
    pv[P_N_TO_K]      = cs03;                                         // [R13]
    // Index memory read: strobe, or clear when cores are not yet valid
    index_read        = pk13 || cs02;
    pv[P_XM_TO_X]     = index_read && !index_sel_zero_i
                     && !(pc_reg_match_i && s_q.first_ref);           // [R14]
    pv[P_X_CLR]       = index_read && (index_sel_zero_i
                     || (pc_reg_match_i && s_q.first_ref));           // [R15] [R19]
    pv[P_X_PAR_SET]   = pv[P_X_CLR];                                  // [R19]
    pv[P_P_TO_X]      = ((pk31 && jump_save_i) || cs04) && index_parity_alarm_ok;   // [R17]
    pv[P_XA_TO_X]     = index_write_i && index_modify_i && index_parity_alarm_ok;   // [R18]
    pv[P_X_COMP]      = (positive_index_jump_i
                         && ((pk15 && !deferred_interlock_i)
                          || (pk25 && !e_busy_flag_i)))               // [R20]
                     || (index_skip_i
                         && ((pk15 && !deferred_interlock_i && cf3_differs_i)
                          || (pk27 && cf3_i) || (pk31 && cf1_i)));    // [R21]
    // Software can hold every pulse off, e.g. while setting switches up
    if (!s_q.ctrl[CTRL_ENABLE]) begin
      pv = '0;
    end
  end

  // ==========================================================
  // Next state
  logic wr_fire;
  logic rd_fire;

  always_comb begin
    s_d       = s_q;
    s_d.pulse = pv;                                                   // [R22]
    if (pv != '0) begin
      s_d.last  = pv;
      s_d.count = s_q.count + 16'h0001;
    end
    // Sequence change sets; a same-cycle PC reference cannot clear it  [R16]
    if (cs_step_i && (cs_level_i == CS_L01)) begin
      s_d.first_ref = 1'b1;
    end else if (pk13 && pc_reg_match_i && !index_sel_zero_i) begin
      s_d.first_ref = 1'b0;                                           // [R16]
    end

    // Write address and data may arrive in either order
    if (s_axi_awvalid && s_axi_awready) begin
      s_d.aw_have = 1'b1;
      s_d.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      s_d.w_have = 1'b1;
      s_d.w_data = s_axi_wdata;
      s_d.w_strb = s_axi_wstrb;
    end
    wr_fire = s_q.aw_have && s_q.w_have && !s_q.bvalid;
    if (wr_fire) begin
      s_d.aw_have = 1'b0;
      s_d.w_have  = 1'b0;
      s_d.bvalid  = 1'b1;
      s_d.bresp   = RESP_OKAY;
      case (s_q.aw_addr)
        ADDR_CTRL: begin
          s_d.ctrl = 3'(merge({29'h0, s_q.ctrl}, s_q.w_data, s_q.w_strb));
        end
        ADDR_STATUS, ADDR_LAST, ADDR_COUNT: begin
          s_d.bresp = RESP_OKAY;
        end
        default: begin
          s_d.bresp = RESP_SLVERR;
        end
      endcase
    end
    if (s_q.bvalid && s_axi_bready) begin
      s_d.bvalid = 1'b0;
    end

    rd_fire = s_axi_arvalid && s_axi_arready;
    if (rd_fire) begin
      s_d.rvalid = 1'b1;
      s_d.rresp  = RESP_OKAY;
      case (s_axi_araddr)
        ADDR_CTRL: begin
          s_d.rdata = {29'h0, s_q.ctrl};
        end
        ADDR_STATUS: begin
          s_d.rdata = {28'h0, alarm_i, index_parity_alarm_i, 1'b0, s_q.first_ref};
        end
        ADDR_LAST: begin
          s_d.rdata = {16'h0, s_q.last};
        end
        ADDR_COUNT: begin
          s_d.rdata = {16'h0, s_q.count};
        end
        default: begin
          s_d.rdata = 32'h0;
          s_d.rresp = RESP_SLVERR;
        end
      endcase
    end else if (s_q.rvalid && s_axi_rready) begin
      s_d.rvalid = 1'b0;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_q           <= '0;
      s_q.ctrl      <= CTRL_RESET;
      s_q.first_ref <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================================
  // Outputs
  assign s_axi_awready = !s_q.aw_have;
  assign s_axi_wready  = !s_q.w_have;
  assign s_axi_bvalid  = s_q.bvalid;
  assign s_axi_bresp   = s_q.bresp;
  assign s_axi_arready = !s_q.rvalid;
  assign s_axi_rvalid  = s_q.rvalid;
  assign s_axi_rdata   = s_q.rdata;
  assign s_axi_rresp   = s_q.rresp;

  assign n_clear_o              = s_q.pulse[P_N_CLR];
  assign n_clear_low_o          = s_q.pulse[P_N_CLR_LOW];
  assign e_to_n_o               = s_q.pulse[P_E_TO_N];
  assign e_low_to_n_low_o       = s_q.pulse[P_E_LO_TO_N];
  assign xa_to_p_o              = s_q.pulse[P_XA_TO_P];
  assign xa29_to_p29_o          = s_q.pulse[P_XA29_TO_P29];
  assign p_inc_o                = s_q.pulse[P_P_INC];
  assign xa_to_q_o              = s_q.pulse[P_XA_TO_Q];
  assign n_to_k_o               = s_q.pulse[P_N_TO_K];
  assign xmem_to_x_o            = s_q.pulse[P_XM_TO_X];
  assign x_clear_o              = s_q.pulse[P_X_CLR];
  assign x_parity_set_o         = s_q.pulse[P_X_PAR_SET];
  assign p_to_x_o               = s_q.pulse[P_P_TO_X];
  assign xa_to_x_o              = s_q.pulse[P_XA_TO_X];
  assign x_complement_o         = s_q.pulse[P_X_COMP];
  assign first_reference_flag_o = s_q.first_ref;

endmodule : reg_pulse_ctrl
`default_nettype wire

// ### test/level_seq.sv
// Far-side model: steps the counter time levels and releases level 25
`timescale 1ns/1ps
`default_nettype none
module level_seq (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // Control
  input  wire logic       run_i,
  input  wire logic       slow_i,
  // Time levels
  output logic            step_o,
  output logic            release_o,
  output logic [4:0]      level_o
);
  // ==========================================================
  // Sequencer
  logic hold_q;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      step_o    <= 1'b0;
      release_o <= 1'b0;
      level_o   <= 5'h00;
      hold_q    <= 1'b0;
    end else begin
      // Slow mode waits a cycle between steps, as a busy memory would
      hold_q    <= slow_i & ~hold_q;
      step_o    <= run_i & ~hold_q;
      level_o   <= level_o + {4'h0, run_i & ~hold_q};
      release_o <= step_o && level_o == 5'h15;
    end
  end
endmodule : level_seq
`default_nettype wire

// ### test/reg_pulse_ctrl_props.sv
// Assertion checker for the register-driver pulse generator
`timescale 1ns/1ps
`default_nettype none
module reg_pulse_ctrl_props
  import reg_pulse_pkg::*;
(
  // Clock, reset and time levels
  input wire logic       clk_i, rst_i, pk_step_i, pk_release_i, qk_step_i, cs_step_i,
  input wire logic [4:0] pk_level_i, qk_level_i,
  input wire logic [2:0] cs_level_i,
  // Conditions
  input wire logic       sel_legal_i, final_deferred_i, jx_class_i, operand_index_i,
  input wire logic       skip_instr_i, skip_cond_i, index_sel_zero_i, pc_reg_match_i,
  // Pulses
  input wire logic       n_clear_o, xa_to_p_o, xa29_to_p29_o, p_inc_o, n_to_k_o,
  input wire logic       xmem_to_x_o, x_clear_o, x_parity_set_o, first_reference_flag_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ==========================================================
  // Pulse causes
  AST_N_CLEAR: assert property (
    n_clear_o |-> $past(pk_step_i && pk_level_i == PK_L10 && (sel_legal_i || final_deferred_i)
      || pk_release_i && jx_class_i || qk_step_i && qk_level_i == QK_L01 && operand_index_i
      || cs_step_i && cs_level_i == CS_L01)) else $error("word clear without cause");
  AST_METABIT: assert property (
    xa29_to_p29_o |-> xa_to_p_o && $past(cs_step_i && cs_level_i == CS_L04))
    else $error("metabit copy outside sequence change");
  AST_P_INC: assert property (
    p_inc_o |-> $past(pk_step_i && (pk_level_i == PK_L24
      || pk_level_i == PK_L31 && skip_instr_i && skip_cond_i))) else $error("stray increment");
  AST_K_JAM: assert property (
    n_to_k_o |-> $past(cs_step_i && cs_level_i == CS_L03)) else $error("stray sequence jam");
  AST_PARITY_SET: assert property (
    (x_parity_set_o || x_clear_o) |-> x_parity_set_o && x_clear_o
      && $past((pk_step_i && pk_level_i == PK_L13 || cs_step_i && cs_level_i == CS_L02)
      && (index_sel_zero_i || pc_reg_match_i && first_reference_flag_o)))
    else $error("parity set apart from buffer clear");
  AST_STROBE: assert property (
    xmem_to_x_o |-> !x_clear_o && $past(!index_sel_zero_i
      && !(pc_reg_match_i && first_reference_flag_o))) else $error("strobe not allowed");
  AST_FLAG_SET: assert property (
    $rose(first_reference_flag_o) |-> $past(cs_step_i && cs_level_i == CS_L01))
    else $error("flag set without sequence change");
  AST_FLAG_CLEAR: assert property (
    $fell(first_reference_flag_o) |-> $past(pk_step_i && pk_level_i == PK_L13
      && pc_reg_match_i && !index_sel_zero_i)) else $error("flag cleared without reference");
  cover property (x_clear_o);
  cover property (xa29_to_p29_o);
  cover property ($fell(first_reference_flag_o));
endmodule : reg_pulse_ctrl_props
bind reg_pulse_ctrl reg_pulse_ctrl_props props (.*);
`default_nettype wire

// ### test/tb_reg_pulse_ctrl.sv
// Self-checking bench for the register-driver pulse generator
`timescale 1ns/1ps
`default_nettype none
module tb_reg_pulse_ctrl;
  import reg_pulse_pkg::*;
  // ==========================================================
  // Signals
  logic clk_i, rst_i, pk_step_i, pk_release_i, qk_step_i, cs_step_i;
  logic [4:0] pk_level_i, qk_level_i, sq_lvl;
  logic [2:0] cs_level_i, mask;
  logic sel_legal_i, final_deferred_i, jx_class_i, operand_index_i, ff_memory_cycle_i;
  logic index_operand_i, plain_jump_i, arithmetic_jump_condition_i, index_jump_condition_i;
  logic alarm_i, skip_instr_i, skip_cond_i, operand_start_interlock_i, deferred_start_i;
  logic deferred_interlock_i, index_sel_zero_i, pc_reg_match_i, jump_save_i;
  logic index_parity_alarm_i, index_modify_i, index_write_i, positive_index_jump_i;
  logic index_skip_i, e_busy_flag_i, cf3_differs_i, cf3_i, cf1_i;
  logic n_clear_o, n_clear_low_o, e_to_n_o, e_low_to_n_low_o, xa_to_p_o, xa29_to_p29_o;
  logic p_inc_o, xa_to_q_o, n_to_k_o, xmem_to_x_o, x_clear_o, x_parity_set_o, p_to_x_o;
  logic xa_to_x_o, x_complement_o, first_reference_flag_o;
  logic [3:0] s_axi_awaddr, s_axi_wstrb, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, c, rd;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic sq_step, sq_rel, slow, go, live, auto_on, sup_on, en_on, flag_m;
  logic [26:0] cv;
  logic [15:0] exp_v, got_v, e_w, last_m;
  integer fails, compares, seed, cyc, cnt_m;

  reg_pulse_ctrl dut (.*);
  level_seq far (.clk_i(clk_i), .rst_i(rst_i), .run_i(go), .slow_i(slow), .step_o(sq_step),
    .release_o(sq_rel), .level_o(sq_lvl));

  assign {sel_legal_i, final_deferred_i, jx_class_i, operand_index_i, ff_memory_cycle_i,
    index_operand_i, plain_jump_i, arithmetic_jump_condition_i, index_jump_condition_i, alarm_i,
    skip_instr_i, skip_cond_i, operand_start_interlock_i, deferred_start_i, deferred_interlock_i,
    index_sel_zero_i, pc_reg_match_i, jump_save_i, index_parity_alarm_i, index_modify_i,
    index_write_i, positive_index_jump_i, index_skip_i, e_busy_flag_i, cf3_differs_i, cf3_i,
    cf1_i} = cv;
  assign got_v = {first_reference_flag_o, x_parity_set_o, x_complement_o, xa_to_x_o, p_to_x_o,
    x_clear_o, xmem_to_x_o, n_to_k_o, xa_to_q_o, p_inc_o, xa29_to_p29_o, xa_to_p_o,
    e_low_to_n_low_o, e_to_n_o, n_clear_low_o, n_clear_o};

  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  // ==========================================================
  // Reference model
  function automatic logic pa(input logic [4:0] v);
    return pk_step_i && pk_level_i == v;
  endfunction : pa
  function automatic logic qa(input logic [4:0] v);
    return qk_step_i && qk_level_i == v;
  endfunction : qa
  function automatic logic ca(input logic [2:0] v);
    return cs_step_i && cs_level_i == v;
  endfunction : ca
  function automatic logic [15:0] expect_vec();
    logic [15:0] e;
    logic ok, xok, ev, clr;
    e = 16'h0000;
    ok = auto_on | !alarm_i;
    xok = sup_on | !index_parity_alarm_i;
    ev = pa(PK_L13) || ca(CS_L02);
    clr = index_sel_zero_i || pc_reg_match_i && flag_m;
    e[P_N_CLR] = pa(PK_L10) && (sel_legal_i || final_deferred_i) || pk_release_i && jx_class_i
      || qa(QK_L01) && operand_index_i || ca(CS_L01);
    e[P_N_CLR_LOW] = pa(PK_L10) && !(sel_legal_i || final_deferred_i);
    e[P_E_TO_N] = pa(PK_L11) && ff_memory_cycle_i;
    e[P_E_LO_TO_N] = (qa(QK_L15) || qa(QK_L21)) && index_operand_i;
    e[P_XA_TO_P] = ok && (pk_release_i && index_jump_condition_i || ca(CS_L04)
      || pa(PK_L31) && (plain_jump_i || arithmetic_jump_condition_i));
    e[P_XA29_TO_P29] = ok && ca(CS_L04);
    e[P_P_INC] = pa(PK_L24) || pa(PK_L31) && skip_instr_i && skip_cond_i;
    e[P_XA_TO_Q] = qa(QK_L00) && operand_start_interlock_i
      || pa(PK_L00) && deferred_start_i && deferred_interlock_i;
    e[P_N_TO_K] = ca(CS_L03);
    e[P_XM_TO_X] = ev && !clr;
    e[P_X_CLR] = ev && clr;
    e[P_X_PAR_SET] = ev && clr;
    e[P_P_TO_X] = xok && (pa(PK_L31) && jump_save_i || ca(CS_L04));
    e[P_XA_TO_X] = xok && index_write_i && index_modify_i;
    e[P_X_COMP] = positive_index_jump_i && (pa(PK_L15) && !deferred_interlock_i
      || pa(PK_L25) && !e_busy_flag_i) || index_skip_i && (pa(PK_L27) && cf3_i
      || pa(PK_L15) && !deferred_interlock_i && cf3_differs_i || pa(PK_L31) && cf1_i);
    if (!en_on) e = 16'h0000;
    return e;
  endfunction : expect_vec

  always @(posedge clk_i) begin
    if (rst_i) begin
      flag_m = 1'b1;
      cnt_m = 0;
      last_m = 16'h0000;
      exp_v = 16'h8000;
    end else begin
      e_w = expect_vec();
      if (ca(CS_L01)) flag_m = 1'b1;
      else if (pa(PK_L13) && pc_reg_match_i && !index_sel_zero_i) flag_m = 1'b0;
      if (e_w != 16'h0000) begin
        cnt_m = cnt_m + 1;
        last_m = e_w;
      end
      exp_v = {flag_m, e_w[14:0]};
    end
  end

  // ==========================================================
  // Stimulus, checks and timeout
  always @(posedge clk_i) begin
    c = $random(seed);
    // Keep the index jump condition inside its instruction class
    c[18] = c[18] & c[24];
    cv <= go ? c[26:0] : 27'h0;
    pk_step_i <= go & sq_step & c[27] & mask[0];
    qk_step_i <= go & sq_step & c[28] & mask[1];
    cs_step_i <= go & sq_step & c[29] & mask[2];
    pk_release_i <= go & sq_rel & mask[0];
    pk_level_i <= sq_lvl;
    qk_level_i <= sq_lvl + 5'h0b;
    cs_level_i <= sq_lvl[2:0];
    cyc = cyc + 1;
    if (cyc > 6000) begin
      fails = fails + 1;
      $display("mismatch at %0t: timeout", $time);
      report_and_stop();
    end
  end

  always @(negedge clk_i) begin
    if (live) check_pulses(got_v, exp_v);
  end

  task automatic check_pulses(input logic [15:0] g, input logic [15:0] e);
    compares = compares + 1;
    if (g !== e) begin
      fails = fails + 1;
      $display("mismatch at %0t: pulses %h expected %h", $time, g, e);
    end
  endtask : check_pulses

  task automatic check_word(input logic [31:0] g, input logic [31:0] e);
    compares = compares + 1;
    if (g !== e) begin
      fails = fails + 1;
      $display("mismatch at %0t: word %h expected %h", $time, g, e);
    end
  endtask : check_word

  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge clk_i);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk_i);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : axi_wr

  task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk_i);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk_i);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : axi_rd

  task automatic run(input int n, input logic s);
    slow <= s;
    go <= 1'b1;
    repeat (n) @(posedge clk_i);
    go <= 1'b0;
    repeat (4) @(posedge clk_i);
  endtask : run

  task automatic report_and_stop();
    if (fails == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : report_and_stop

  initial begin
    seed = 71;
    {fails, compares, cyc} = '0;
    {go, live, slow, auto_on, sup_on, s_axi_awvalid, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hf;
    en_on = 1'b1;
    mask = 3'h7;
    rst_i = 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    live <= 1'b1;
    axi_rd(ADDR_CTRL, rd, rr);
    check_word(rd, 32'h4);
    axi_rd(ADDR_STATUS, rd, rr);
    check_word(rd & 32'h1, 32'h1);
    axi_rd(4'h2, rd, rr);
    check_word({30'h0, rr}, {30'h0, RESP_SLVERR});
    run(600, 1'b0);
    axi_wr(ADDR_CTRL, 32'h7, rr);
    auto_on = 1'b1;
    sup_on = 1'b1;
    run(600, 1'b1);
    // Disabled: only operand steps, so the flag stays put
    axi_wr(ADDR_CTRL, 32'h3, rr);
    en_on = 1'b0;
    mask = 3'h2;
    run(200, 1'b0);
    axi_rd(ADDR_LAST, rd, rr);
    check_word(rd, {16'h0, last_m});
    axi_rd(ADDR_COUNT, rd, rr);
    check_word(rd, cnt_m & 32'hffff);
    axi_wr(4'h2, 32'h0, rr);
    check_word({30'h0, rr}, {30'h0, RESP_SLVERR});
    report_and_stop();
  end
endmodule : tb_reg_pulse_ctrl
`default_nettype wire
